// File: common/lbc_pkg.sv
// Constants shared by the status lamp blink controller
package lbc_pkg;
    // Register map (byte addresses)
    localparam logic [7:0] ADDR_BLINK_CONFIG = 8'h2c;
    localparam logic [7:0] ADDR_CONTROL      = 8'h30;
    localparam logic [7:0] ADDR_STATUS       = 8'h34;
    // Field positions of led_blink_config
    localparam int BIT_TWO_LAMPS   = 7;
    localparam int BIT_KEEP_S45    = 6;
    localparam int LAMP2_LSB       = 3;
    localparam int LAMP1_LSB       = 0;
    // Reset values
    localparam logic [7:0] BLINK_CONFIG_RESET = 8'h38;
    localparam logic [1:0] MODE_RESET         = 2'h0;
    // Blink codes
    localparam logic [2:0] CODE_OFF    = 3'h0;
    localparam logic [2:0] CODE_1HZ    = 3'h3;
    localparam logic [2:0] CODE_ON     = 3'h7;
    // Lamp modes
    localparam logic [1:0] MODE_SW  = 2'h0;
    localparam logic [1:0] MODE_HW1 = 2'h1;
    localparam logic [1:0] MODE_HW2 = 2'h2;
    // Time base: 1/48 s ticks make 2, 3 and 4 Hz exact
    localparam int  CLK_HZ        = 20_000_000;
    localparam int  TICK_HZ       = 48;
    localparam int  TICK_CYCLES   = CLK_HZ / TICK_HZ;
    localparam int  PHASE_TICKS   = 192;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : lbc_pkg

// File: logic/lbc_top.sv
// Status lamp blink controller with AXI4-Lite register access
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module lbc_top #(
    parameter int TICK_CYCLES = lbc_pkg::TICK_CYCLES
) (
    // Clock and battery reset
    input  wire logic        i_mclk,
    input  wire logic        i_resetn,
    // Power events
    input  wire logic        i_standby_supply_up,
    input  wire logic        i_main_power_lost,
    input  wire logic        i_sleep_s4_s5,
    // AXI4-Lite write address and data
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Lamps
    output logic             o_first_status_lamp,
    output logic             o_second_status_lamp
);
    // Divider counter is 20 bits wide
    if (TICK_CYCLES < 2 || TICK_CYCLES > 1_048_576) begin : g_tick_range
        $error("TICK_CYCLES out of range");
    end

    typedef enum logic [1:0] {
        LBC_W_IDLE = 2'b00,
        LBC_W_RESP = 2'b01
    } lbc_wstate_e;

    typedef struct packed {
        logic [7:0]  cfg;
        logic [1:0]  mode;
        logic [19:0] div;
        logic        tick;
        logic [7:0]  phase;
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        w_held;
        logic [7:0]  w_data;
        logic        w_lane0;
        lbc_wstate_e wstate;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        lamp1;
        logic        lamp2;
        logic        prev_sb;
        logic        prev_lost;
        logic        aw_rdy;
        logic        w_rdy;
        logic        ar_rdy;
    } lbc_state_s;

    lbc_state_s st;
    lbc_state_s next_st;

    // Blink wave for a code at a phase of 192 ticks of 1/48 s
    function automatic logic lbc_wave(input logic [2:0] code, input logic [7:0] ph);
        logic [7:0] m;
        m = 8'h00;
        case (code)
            3'h0: lbc_wave = 1'b0;
            3'h1: lbc_wave = (ph < 8'd24);
            3'h2: begin
                m = ph % 8'd96;
                lbc_wave = (m < 8'd24);
            end
            3'h3: begin
                m = ph % 8'd48;
                lbc_wave = (m < 8'd24);
            end
            3'h4: begin
                m = ph % 8'd24;
                lbc_wave = (m < 8'd12);
            end
            3'h5: begin
                m = ph % 8'd16;
                lbc_wave = (m < 8'd8);
            end
            3'h6: begin
                m = ph % 8'd12;
                lbc_wave = (m < 8'd6);
            end
            default: lbc_wave = 1'b1;
        endcase
    endfunction : lbc_wave

    function automatic logic [31:0] lbc_read(input logic [7:0] a, input lbc_state_s s);
        case (a)
            lbc_pkg::ADDR_BLINK_CONFIG: lbc_read = {24'h000000, s.cfg};
            lbc_pkg::ADDR_CONTROL:      lbc_read = {30'h00000000, s.mode};
            lbc_pkg::ADDR_STATUS:       lbc_read = {24'h000000, s.phase};
            default:                    lbc_read = 32'h00000000;
        endcase
    endfunction : lbc_read

    function automatic logic lbc_mapped(input logic [7:0] a);
        lbc_mapped = (a == lbc_pkg::ADDR_BLINK_CONFIG) || (a == lbc_pkg::ADDR_CONTROL)
                  || (a == lbc_pkg::ADDR_STATUS);
    endfunction : lbc_mapped

    logic sb_rise;
    logic lost_rise;
    logic w_go;
    logic l1;
    logic l2;
    // Standby taken as present at battery reset, so no false power-up event
    assign sb_rise   = i_standby_supply_up & ~st.prev_sb;
    assign lost_rise = i_main_power_lost & ~st.prev_lost & i_standby_supply_up;
    assign w_go      = st.aw_held & st.w_held & (st.wstate == LBC_W_IDLE);

    always_comb begin
        next_st = st;
        next_st.prev_sb   = i_standby_supply_up;
        next_st.prev_lost = i_main_power_lost;
        // Tick divider and phase
        next_st.tick = 1'b0;
        if (st.div == 20'(TICK_CYCLES - 1)) begin
            next_st.div  = 20'h00000;
            next_st.tick = 1'b1;
        end else begin
            next_st.div = st.div + 20'h00001;
        end
        if (st.tick) begin
            next_st.phase = (st.phase == 8'(lbc_pkg::PHASE_TICKS - 1)) ? 8'h00
                                                                      : st.phase + 8'h01;
        end
        // Write channel capture, either order
        if (s_axi_awvalid && !st.aw_held) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_held) begin
            next_st.w_held  = 1'b1;
            next_st.w_data  = s_axi_wdata[7:0];
            next_st.w_lane0 = s_axi_wstrb[0];
        end
        case (st.wstate)
            LBC_W_IDLE: begin
                if (w_go) begin
                    if (st.w_lane0 && st.aw_addr == lbc_pkg::ADDR_BLINK_CONFIG) begin
                        next_st.cfg = st.w_data;
                    end
                    if (st.w_lane0 && st.aw_addr == lbc_pkg::ADDR_CONTROL) begin
                        next_st.mode = st.w_data[1:0];
                    end
                    next_st.bvalid = 1'b1;
                    next_st.bresp  = lbc_mapped(st.aw_addr) ? lbc_pkg::RESP_OKAY
                                                            : lbc_pkg::RESP_SLVERR;
                    next_st.wstate = LBC_W_RESP;
                end
            end
            LBC_W_RESP: begin
                if (s_axi_bready) begin
                    next_st.bvalid  = 1'b0;
                    next_st.aw_held = 1'b0;
                    next_st.w_held  = 1'b0;
                    next_st.wstate  = LBC_W_IDLE;
                end
            end
            default: next_st.wstate = LBC_W_IDLE;
        endcase
        // Power events win over a same-cycle software write
        // hardware mode 1 reload
        if ((sb_rise || lost_rise) && st.mode == lbc_pkg::MODE_HW1) begin
            next_st.cfg[lbc_pkg::LAMP2_LSB +: 3] = lbc_pkg::CODE_1HZ;
        end
        if (lost_rise) begin
            next_st.cfg[lbc_pkg::BIT_KEEP_S45] = 1'b0;
        end
        // Read channel
        if (st.rvalid) begin
            if (s_axi_rready) begin
                next_st.rvalid = 1'b0;
            end
        end else if (s_axi_arvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = lbc_read(s_axi_araddr, st);
            next_st.rresp  = lbc_mapped(s_axi_araddr) ? lbc_pkg::RESP_OKAY
                                                     : lbc_pkg::RESP_SLVERR;
        end
        l1 = lbc_wave(st.cfg[lbc_pkg::LAMP1_LSB +: 3], st.phase);
        l2 = lbc_wave(st.cfg[lbc_pkg::LAMP2_LSB +: 3], st.phase);
        // one dual lamp shows only one colour at a time
        if (!st.cfg[lbc_pkg::BIT_TWO_LAMPS] && l1) begin
            l2 = 1'b0;
        end
        // power lamp off in S4/S5 only in hardware mode 2
        if (i_sleep_s4_s5 && st.mode == lbc_pkg::MODE_HW2
                && !st.cfg[lbc_pkg::BIT_KEEP_S45]) begin
            l1 = 1'b0;
        end
        next_st.lamp1 = l1;
        next_st.lamp2 = l2;
        // Ready flags registered so every bus output leaves a flop
        next_st.aw_rdy = !next_st.aw_held;
        next_st.w_rdy  = !next_st.w_held;
        next_st.ar_rdy = !next_st.rvalid;
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            st       <= '0;
            st.cfg   <= lbc_pkg::BLINK_CONFIG_RESET;
            st.mode  <= lbc_pkg::MODE_RESET;
            st.lamp2 <= 1'b1;
            st.prev_sb <= 1'b1;
            st.aw_rdy <= 1'b1;
            st.w_rdy <= 1'b1;
            st.ar_rdy <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready        = st.aw_rdy;
    assign s_axi_wready         = st.w_rdy;
    assign s_axi_bvalid         = st.bvalid;
    assign s_axi_bresp          = st.bresp;
    assign s_axi_arready        = st.ar_rdy;
    assign s_axi_rvalid         = st.rvalid;
    assign s_axi_rdata          = st.rdata;
    assign s_axi_rresp          = st.rresp;
    assign o_first_status_lamp  = st.lamp1;
    assign o_second_status_lamp = st.lamp2;

    // Assertions
    a_write_stores: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        w_go && st.w_lane0 && st.aw_addr == lbc_pkg::ADDR_BLINK_CONFIG
        && !sb_rise && !lost_rise |=> st.cfg == $past(st.w_data))
        else $error("config write lost");
    a_code_off_low: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        st.cfg[2:0] == lbc_pkg::CODE_OFF |=> !o_first_status_lamp)
        else $error("lamp 1 lit with code off");
    a_code_on_high: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        st.cfg[5:3] == lbc_pkg::CODE_ON && st.cfg[7] |=> o_second_status_lamp)
        else $error("lamp 2 dark with code on");
    a_dual_exclusive: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        !st.cfg[7] |=> !(o_first_status_lamp && o_second_status_lamp))
        else $error("dual lamp both colours");
    a_sleep_off: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        i_sleep_s4_s5 && st.mode == lbc_pkg::MODE_HW2 && !st.cfg[6] |=> !o_first_status_lamp)
        else $error("power lamp lit in sleep");
    a_mode1_reload: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        sb_rise && st.mode == lbc_pkg::MODE_HW1 |=> st.cfg[5:3] == lbc_pkg::CODE_1HZ)
        else $error("mode 1 reload missing");
    a_mode3_ignore: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        st.mode != lbc_pkg::MODE_HW2 && st.cfg[2:0] == lbc_pkg::CODE_ON |=> o_first_status_lamp)
        else $error("keep bit acted outside mode 2");
    a_slow_duty: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        st.cfg[2:0] == 3'h1 && st.phase == 8'd30 && !i_sleep_s4_s5 |=> !o_first_status_lamp)
        else $error("0.25 Hz duty wrong");
    a_bresp_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_loss_clears_keep: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        lost_rise |=> !st.cfg[lbc_pkg::BIT_KEEP_S45])
        else $error("keep bit survived main loss");
    a_loss_reload: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        lost_rise && st.mode == lbc_pkg::MODE_HW1 |=> st.cfg[5:3] == lbc_pkg::CODE_1HZ)
        else $error("mode 1 loss reload missing");
    a_rdata_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    c_write: cover property (@(posedge i_mclk) disable iff (!i_resetn) w_go);
    c_read: cover property (@(posedge i_mclk) disable iff (!i_resetn) s_axi_rvalid && s_axi_rready);
    c_reload: cover property (@(posedge i_mclk) disable iff (!i_resetn)
        lost_rise && st.mode == lbc_pkg::MODE_HW1);
    c_sleep_dark: cover property (@(posedge i_mclk) disable iff (!i_resetn)
        i_sleep_s4_s5 && st.mode == lbc_pkg::MODE_HW2 && !st.cfg[lbc_pkg::BIT_KEEP_S45]);
    c_dual_share: cover property (@(posedge i_mclk) disable iff (!i_resetn)
        !st.cfg[lbc_pkg::BIT_TWO_LAMPS] && st.lamp1);
endmodule : lbc_top

// File: verification/lbc_lamp_model.sv
// Front panel lamp model that totals lit cycles over a window
`timescale 1ns/1ps
module lbc_lamp_model (
    // Clock and window restart
    input  wire logic   i_mclk,
    input  wire logic   i_clear,
    // Lamp drive and lit total
    input  wire logic   i_lamp,
    output logic [15:0] o_lit_cycles
);
    // A lamp only shows light; it keeps no state beyond the lit total
    always_ff @(posedge i_mclk) begin
        if (i_clear) begin
            o_lit_cycles <= 16'h0;
        end else if (i_lamp) begin
            o_lit_cycles <= o_lit_cycles + 16'h1;
        end
    end
endmodule : lbc_lamp_model

// File: verification/testbench.sv
// Self-checking bench for the status lamp blink controller
`timescale 1ns/1ps
module testbench;
    localparam int TC = 4;
    localparam int W  = 192 * TC;
    typedef struct packed {logic [7:0] cfg; logic [15:0] lit1; logic [15:0] lit2;} lbc_row_s;
    logic        clk, rstn, sby, mloss, slp, clr, lamp1, lamp2;
    logic        awv, awy, wv, wy, bv, by, arv, ary, rv, ry;
    logic [7:0]  awa, ara;
    logic [3:0]  ws;
    logic [31:0] wd, rd, got;
    logic [1:0]  bresp, rresp, resp;
    logic [15:0] lit1, lit2;
    int          bad_count, n_tests;
    lbc_row_s    rows [9];

    lbc_top #(.TICK_CYCLES(TC)) dut (
        .i_mclk(clk), .i_resetn(rstn), .i_standby_supply_up(sby),
        .i_main_power_lost(mloss), .i_sleep_s4_s5(slp),
        .s_axi_awvalid(awv), .s_axi_awready(awy), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wy), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_bvalid(bv), .s_axi_bready(by), .s_axi_bresp(bresp),
        .s_axi_arvalid(arv), .s_axi_arready(ary), .s_axi_araddr(ara),
        .s_axi_rvalid(rv), .s_axi_rready(ry), .s_axi_rdata(rd), .s_axi_rresp(rresp),
        .o_first_status_lamp(lamp1), .o_second_status_lamp(lamp2));
    lbc_lamp_model lamp_a (.i_mclk(clk), .i_clear(clr), .i_lamp(lamp1), .o_lit_cycles(lit1));
    lbc_lamp_model lamp_b (.i_mclk(clk), .i_clear(clr), .i_lamp(lamp2), .o_lit_cycles(lit2));

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("Checks made: %0d, mismatches: %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    // Write: both channels offered together, each dropped once taken
    task automatic wrchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge clk);
        {awv, wv, by, awa, wd} <= {3'b111, a, d};
        do begin
            @(posedge clk);
            if (awy) awv <= 1'b0;
            if (wy) wv <= 1'b0;
        end while (!bv);
        by <= 1'b0;
        chk({30'h0, bresp}, {30'h0, e});
    endtask : wrchk

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        {arv, ry, ara} <= {2'b11, a};
        do begin
            @(posedge clk);
            if (ary) arv <= 1'b0;
        end while (!rv);
        ry <= 1'b0;
        chk(rd, e);
        chk({30'h0, rresp}, {30'h0, er});
    endtask : rdchk

    task automatic settle();
        repeat (4) @(posedge clk);
    endtask : settle

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (30000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        {awv, wv, by, arv, ry, clr, mloss, slp, rstn, awa, ara, wd} = '0;
        sby = 1'b1;
        ws = 4'hf;
        // Lit totals over 192 ticks: both lamps cover every code
        rows = '{'{8'hb8, 16'd0, 16'd768}, '{8'hb1, 16'd96, 16'd384},
                 '{8'haa, 16'd192, 16'd384}, '{8'ha3, 16'd384, 16'd384},
                 '{8'h9c, 16'd384, 16'd384}, '{8'h95, 16'd384, 16'd192},
                 '{8'h8e, 16'd384, 16'd96}, '{8'h87, 16'd768, 16'd0},
                 '{8'h3c, 16'd384, 16'd384}};
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            wrchk(8'h2c, {24'h0, rows[i].cfg}, 2'h0);
            clr <= 1'b1;
            @(posedge clk);
            clr <= 1'b0;
            repeat (W) @(posedge clk);
            #1;
            chk({16'h0, lit1}, {16'h0, rows[i].lit1});
            chk({16'h0, lit2}, {16'h0, rows[i].lit2});
        end
        // Mid-run battery reset
        @(posedge clk);
        rstn <= 1'b0;
        settle();
        chk({31'h0, lamp1}, 32'h0);
        chk({31'h0, lamp2}, 32'h1);
        chk({29'h0, awy, wy, ary}, 32'h7);
        rstn <= 1'b1;
        rdchk(8'h34, 32'h0, 2'h0);
        rdchk(8'h2c, 32'h38, 2'h0);
        wrchk(8'h2c, 32'hff, 2'h0);
        rdchk(8'h2c, 32'hff, 2'h0);
        wrchk(8'h40, 32'h5a, 2'h2);
        rdchk(8'h40, 32'h0, 2'h2);
        ws <= 4'he;
        wrchk(8'h2c, 32'h00, 2'h0);
        ws <= 4'hf;
        rdchk(8'h2c, 32'hff, 2'h0);
        wrchk(8'h30, 32'h2, 2'h0);
        wrchk(8'h2c, 32'h87, 2'h0);
        slp <= 1'b1;
        settle();
        chk({31'h0, lamp1}, 32'h0);
        wrchk(8'h2c, 32'hc7, 2'h0);
        settle();
        chk({31'h0, lamp1}, 32'h1);
        wrchk(8'h30, 32'h0, 2'h0);
        wrchk(8'h2c, 32'h87, 2'h0);
        settle();
        chk({31'h0, lamp1}, 32'h1);
        slp <= 1'b0;
        wrchk(8'h2c, 32'hc7, 2'h0);
        mloss <= 1'b1;
        settle();
        rdchk(8'h2c, 32'h87, 2'h0);
        mloss <= 1'b0;
        // Hardware mode 1 reloads the second lamp code
        wrchk(8'h30, 32'h1, 2'h0);
        mloss <= 1'b1;
        settle();
        rdchk(8'h2c, 32'h9f, 2'h0);
        mloss <= 1'b0;
        wrchk(8'h2c, 32'h87, 2'h0);
        sby <= 1'b0;
        settle();
        sby <= 1'b1;
        settle();
        rdchk(8'h2c, 32'h9f, 2'h0);
        tally_and_finish();
    end
endmodule : testbench
